/* File: hdl/print_map.svh */
`ifndef PRINT_MAP_SVH
`define PRINT_MAP_SVH

// Clock and printer link
`define CLK_HZ          100000000
`define BAUD_RATE       9600
`define DATA_BITS       8
`define STOP_BITS       1

// Register offsets on the plain register port
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_TXDATA      4'h8
`define REG_ELAPSED     4'hC

// Interval period in seconds; zero disables interval printing
`define INTERVAL_OFF    12'h000
`define INTERVAL_MAX    12'hE10

// Record count range
`define COUNT_FIRST     15'h0001
`define COUNT_LAST      15'h7530

// Elapsed time limits
`define SEC_LAST        6'h3B
`define MIN_LAST        6'h3B
`define HOUR_LAST       7'h63

`endif

/* File: hdl/print_pkg.sv */
package print_pkg;

    typedef enum logic [2:0] {
        SCREEN_MEASURE = 3'h1,
        SCREEN_STATS   = 3'h2,
        SCREEN_OTHER   = 3'h4
    } screen_e;

    typedef enum logic [2:0] {
        JOB_MEASURE  = 3'h1,
        JOB_INTERVAL = 3'h2,
        JOB_STATS    = 3'h4
    } job_kind_e;

    typedef enum logic [1:0] {
        STATS_COUNT_ONLY   = 2'h0,
        STATS_NO_DEVIATION = 2'h1,
        STATS_FULL         = 2'h2
    } stats_level_e;

    typedef enum logic [1:0] {
        RUN_IDLE   = 2'b01,
        RUN_ACTIVE = 2'b10
    } run_state_e;

    typedef struct packed {
        logic [6:0] hours;
        logic [5:0] minutes;
        logic [5:0] seconds;
    } hms_s;

    typedef struct packed {
        job_kind_e    kind;
        logic [14:0]  record_count;
        hms_s         elapsed;
        stats_level_e stats_level;
    } print_job_s;

endpackage : print_pkg

/* File: hdl/serial_tx.sv */
`timescale 1ns/100ps
`include "print_map.svh"

module serial_tx #(
    parameter int BIT_CYCLES = `CLK_HZ / `BAUD_RATE,
    parameter int DATA_BITS  = `DATA_BITS
) (
    // Clock and reset
    input  logic                 ref_clk,
    input  logic                 rst_n,
    input  logic                 clk_en,
    // Byte in
    input  logic                 start,
    input  logic [DATA_BITS-1:0] data,
    // Line out
    output logic                 txd_q,
    output logic                 busy_q
);

    localparam int FRAME_W = DATA_BITS + 1 + `STOP_BITS;
    localparam int CYC_W   = $clog2(BIT_CYCLES + 1);
    localparam int BITS_W  = $clog2(FRAME_W + 1);

    logic [FRAME_W-2:0] shift_q;
    logic [CYC_W-1:0]   cyc_q;
    logic [BITS_W-1:0]  bits_left_q;
    logic               bit_end;

    assign bit_end = (cyc_q == CYC_W'(BIT_CYCLES - 1));

    // RQ1: start, data LSB first, stop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            txd_q       <= 1'b1;
            busy_q      <= 1'b0;
            shift_q     <= '1;
            cyc_q       <= '0;
            bits_left_q <= '0;
        end else if (clk_en) begin
            if (!busy_q) begin
                if (start) begin
                    txd_q       <= 1'b0;
                    busy_q      <= 1'b1;
                    shift_q     <= {{`STOP_BITS{1'b1}}, data};
                    cyc_q       <= '0;
                    bits_left_q <= BITS_W'(FRAME_W - 1);
                end
            end else if (!bit_end) begin
                cyc_q <= cyc_q + CYC_W'(1);
            end else if (bits_left_q == '0) begin
                // Line rests high between frames; no flow control to wait on
                txd_q  <= 1'b1;
                busy_q <= 1'b0;
            end else begin
                txd_q       <= shift_q[0];
                shift_q     <= {1'b1, shift_q[FRAME_W-2:1]};
                cyc_q       <= '0;
                bits_left_q <= bits_left_q - BITS_W'(1);
            end
        end
    end

    a_start_bit_low: assert property (  // RQ1
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && start && !busy_q |=> !txd_q && busy_q)
        else $error("start bit not driven low");

    a_frame_ends_high: assert property (  // RQ1
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(busy_q) |-> txd_q)
        else $error("frame did not end on a stop level");

endmodule : serial_tx

/* File: hdl/interval_print_controller.sv */
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "print_map.svh"

// How it works
// RQ1: 9600 baud, 8N1 serial, no flow control
// RQ2: Printer prints plain text, 45 columns
// RQ3: Measure screen request prints value and decision
// RQ4: Record count runs 1..30000 then wraps
// RQ5: Interval period is 1..3600 seconds
// RQ6: Zero interval gives single ordinary printouts
// RQ7: Requests toggle interval printing on and off
// RQ8: Each interval prints elapsed time and values; a tick that meets a request is dropped
// RQ9: Elapsed time wraps to zero at 100h
// RQ10: Leaving measure screen stops interval printing
// RQ11: Stats screen key prints statistical results
// RQ12: No valid samples prints count only
// RQ13: One sample omits deviation and capability
// RQ14: Stats trigger adds value and prints it
// RQ15: Far side may tie end-of-measure to request
// RQ16: External inputs are active low pulls
// RQ17: Synchronise request, act on new edge only
module interval_print_controller #(
    parameter int SEC_CYCLES = `CLK_HZ,
    parameter int BIT_CYCLES = `CLK_HZ / `BAUD_RATE
) (
    // Clock and reset
    input  logic                   ref_clk,
    input  logic                   rst_n,
    input  logic                   clk_en,
    // Front panel and screen state
    input  logic                   print_key,
    input  logic                   trigger_key,
    input  print_pkg::screen_e     screen,
    // External control port pins, active low
    input  logic                   print_req_n,
    input  logic                   measure_trigger_n,
    // Statistics unit
    input  logic                   stats_enable,
    input  logic                   internal_trigger_sel,
    input  logic [15:0]            stats_valid_count,
    // Register port
    input  logic [3:0]             reg_addr,
    input  logic [31:0]            reg_wdata,
    input  logic                   reg_wr,
    input  logic                   reg_rd,
    output logic [31:0]            reg_rdata_q,
    // Print jobs to the text formatter
    output logic                   job_valid_q,
    output print_pkg::print_job_s  job_q,
    output logic                   stats_add_q,
    output logic                   running_q,
    // Printer link
    output logic                   txd_q
);

    localparam int PRE_W = $clog2(SEC_CYCLES + 1);

    function automatic logic [14:0] next_count(input logic [14:0] c);
        return (c >= `COUNT_LAST) ? `COUNT_FIRST : c + 15'h0001;
    endfunction : next_count

    function automatic print_pkg::stats_level_e level_of(input logic [15:0] n);
        return (n == 16'h0000) ? print_pkg::STATS_COUNT_ONLY :
               (n == 16'h0001) ? print_pkg::STATS_NO_DEVIATION : print_pkg::STATS_FULL;
    endfunction : level_of

    function automatic print_pkg::hms_s hms_inc(input print_pkg::hms_s t);
        print_pkg::hms_s r;
        r = t;
        if (t.seconds != `SEC_LAST) begin
            r.seconds = t.seconds + 6'h01;
        end else begin
            r.seconds = 6'h00;
            if (t.minutes != `MIN_LAST) begin
                r.minutes = t.minutes + 6'h01;
            end else begin
                r.minutes = 6'h00;
                r.hours   = (t.hours >= `HOUR_LAST) ? 7'h00 : t.hours + 7'h01;
            end
        end
        return r;
    endfunction : hms_inc

    logic [1:0]              req_sync_q, measure_trigger_input_sync_q;
    logic                    req_prev_q, measure_trigger_input_prev_q;
    print_pkg::run_state_e   run_q;
    print_pkg::run_state_e   run_d;
    logic [PRE_W-1:0]        pre_q;
    print_pkg::hms_s         elapsed_q;
    print_pkg::hms_s         elapsed_next;
    logic [11:0]             since_q;
    logic [11:0]             since_next;
    logic [11:0]             interval_q;
    logic [14:0]             count_q;
    logic                    tx_busy, tx_start;

    logic req_edge, measure_trigger_input_edge, print_req, measure_trigger_input_evt, on_measure;
    logic interval_on, running, sec_tick, interval_due, stats_print;
    logic stats_measure_trigger_input, start_run, stop_run, measure_print, count_adv;
    logic job_valid_d;
    print_pkg::print_job_s job_d;

    // RQ17: two-stage synchronisers for the pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_sync_q  <= 2'h3;
            measure_trigger_input_sync_q <= 2'h3;
            req_prev_q  <= 1'b1;
            measure_trigger_input_prev_q <= 1'b1;
        end else if (clk_en) begin
            req_sync_q  <= {req_sync_q[0], print_req_n};
            measure_trigger_input_sync_q <= {measure_trigger_input_sync_q[0], measure_trigger_n};
            req_prev_q  <= req_sync_q[1];
            measure_trigger_input_prev_q <= measure_trigger_input_sync_q[1];
        end
    end

    // RQ17: act on the high-to-low edge only
    assign req_edge  = req_prev_q & ~req_sync_q[1];
    assign measure_trigger_input_edge = measure_trigger_input_prev_q & ~measure_trigger_input_sync_q[1];

    assign print_req    = print_key | req_edge;
    assign measure_trigger_input_evt     = trigger_key | measure_trigger_input_edge;
    assign on_measure   = (screen == print_pkg::SCREEN_MEASURE);
    assign interval_on  = (interval_q != `INTERVAL_OFF);
    assign running      = (run_q == print_pkg::RUN_ACTIVE);
    assign sec_tick     = running && (pre_q == PRE_W'(SEC_CYCLES - 1));
    assign elapsed_next = hms_inc(elapsed_q);
    assign since_next   = since_q + 12'h001;
    assign interval_due = sec_tick && (since_next >= interval_q);

    // RQ11: only the key prints statistics
    assign stats_print = (screen == print_pkg::SCREEN_STATS) && print_key;
    // RQ14: internal trigger with statistics on
    assign stats_measure_trigger_input  = stats_enable && internal_trigger_sel && measure_trigger_input_evt;
    // RQ7: a request toggles interval printing
    assign start_run   = on_measure && print_req && interval_on && !running;
    // RQ10: leaving the measure screen also stops it
    assign stop_run    = running && (!on_measure || print_req || !interval_on);
    // RQ3: RQ6: ordinary printout when interval is off
    assign measure_print = (on_measure && print_req && !interval_on) || stats_measure_trigger_input;
    assign count_adv     = !stats_print && measure_print;

    // One job per cycle; a tick that meets a request is dropped
    always_comb begin
        job_valid_d              = 1'b0;
        job_d                    = '0;
        job_d.kind               = print_pkg::JOB_MEASURE;
        job_d.stats_level        = print_pkg::STATS_COUNT_ONLY;
        if (stats_print) begin
            job_valid_d       = 1'b1;
            job_d.kind        = print_pkg::JOB_STATS;
            // RQ12: RQ13: content depends on valid samples
            job_d.stats_level = level_of(stats_valid_count);
        end else if (measure_print) begin
            job_valid_d        = 1'b1;
            job_d.record_count = count_q;
        end else if (start_run) begin
            // RQ8: first record at 00:00:00
            job_valid_d = 1'b1;
            job_d.kind  = print_pkg::JOB_INTERVAL;
        end else if (interval_due && !stop_run) begin
            // RQ8: record elapsed time each period
            job_valid_d   = 1'b1;
            job_d.kind    = print_pkg::JOB_INTERVAL;
            job_d.elapsed = elapsed_next;
        end
    end

    assign run_d = start_run ? print_pkg::RUN_ACTIVE : stop_run ? print_pkg::RUN_IDLE : run_q;

    // RQ7: interval state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q     <= print_pkg::RUN_IDLE;
            running_q <= 1'b0;
        end else if (clk_en) begin
            run_q     <= run_d;
            running_q <= (run_d == print_pkg::RUN_ACTIVE);
        end
    end

    // RQ9: elapsed time and period counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q     <= '0;
            elapsed_q <= '0;
            since_q   <= '0;
        end else if (clk_en) begin
            if (start_run) begin
                pre_q     <= '0;
                elapsed_q <= '0;
                since_q   <= '0;
            end else if (running) begin
                pre_q <= sec_tick ? '0 : pre_q + PRE_W'(1);
                if (sec_tick) begin
                    elapsed_q <= elapsed_next;
                    since_q   <= interval_due ? 12'h000 : since_next;
                end
            end
        end
    end

    // RQ4: running record count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= `COUNT_FIRST;
        end else if (clk_en && count_adv) begin
            count_q <= next_count(count_q);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            job_valid_q <= 1'b0;
            job_q       <= '0;
            stats_add_q <= 1'b0;
        end else if (clk_en) begin
            job_valid_q <= job_valid_d;
            job_q       <= job_d;
            // RQ14: add value to statistics
            stats_add_q <= stats_measure_trigger_input;
        end
    end

    // RQ5: period register, saturates at the top
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            interval_q <= `INTERVAL_OFF;
        end else if (clk_en && reg_wr && reg_addr == `REG_CTRL) begin
            interval_q <= (reg_wdata[11:0] > `INTERVAL_MAX) ? `INTERVAL_MAX : reg_wdata[11:0];
        end
    end

    // Unmapped reads answer zero; data stands only in the cycle after the read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= '0;
        end else if (clk_en) begin
            reg_rdata_q <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    `REG_CTRL:    reg_rdata_q <= {20'h00000, interval_q};
                    `REG_STATUS:  reg_rdata_q <= {1'b0, count_q, 14'h0000, tx_busy, running};
                    `REG_ELAPSED: reg_rdata_q <= {13'h0000, elapsed_q};
                    default:      reg_rdata_q <= '0;
                endcase
            end
        end
    end

    // A byte written while the line is busy is dropped; software polls busy
    assign tx_start = reg_wr && (reg_addr == `REG_TXDATA) && !tx_busy;

    // RQ1: serial printer link
    serial_tx #(
        .BIT_CYCLES (BIT_CYCLES),
        .DATA_BITS  (`DATA_BITS)
    ) u_serial_tx (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .start   (tx_start),
        .data    (reg_wdata[7:0]),
        .txd_q   (txd_q),
        .busy_q  (tx_busy)
    );

    sequence s_start_req;
        clk_en && on_measure && print_req && interval_on && !running;
    endsequence

    sequence s_stop_req;
        clk_en && running && on_measure && print_req;
    endsequence

    a_count_range: assert property (  // RQ4
        @(posedge ref_clk) disable iff (!rst_n)
        job_valid_q && job_q.kind == print_pkg::JOB_MEASURE |->
        job_q.record_count >= `COUNT_FIRST && job_q.record_count <= `COUNT_LAST)
        else $error("record count out of range");

    a_count_wrap_one: assert property (  // RQ4
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && count_adv && count_q == `COUNT_LAST |=> count_q == `COUNT_FIRST)
        else $error("record count did not wrap to one");

    a_interval_limit: assert property (  // RQ5
        @(posedge ref_clk) disable iff (!rst_n)
        interval_q <= `INTERVAL_MAX)
        else $error("interval above limit");

    a_zero_single_print: assert property (  // RQ6
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && on_measure && print_req && !interval_on && !stats_measure_trigger_input |=>
        job_valid_q && job_q.kind == print_pkg::JOB_MEASURE && !running_q)
        else $error("zero interval did not give a single printout");

    a_toggle_start: assert property (  // RQ7
        @(posedge ref_clk) disable iff (!rst_n)
        s_start_req ##0 !stats_measure_trigger_input |=> running_q && job_valid_q
        && job_q.kind == print_pkg::JOB_INTERVAL && job_q.elapsed == '0)
        else $error("request did not start interval printing");

    a_toggle_stop: assert property (  // RQ7
        @(posedge ref_clk) disable iff (!rst_n)
        s_stop_req |=> !running_q ##1
        (running_q || !(job_valid_q && job_q.kind == print_pkg::JOB_INTERVAL)))
        else $error("request did not stop interval printing");

    a_hours_below_hundred: assert property (  // RQ9
        @(posedge ref_clk) disable iff (!rst_n)
        elapsed_q.hours <= `HOUR_LAST && job_q.elapsed.hours <= `HOUR_LAST)
        else $error("elapsed hours reached 100");

    a_leave_screen_stops: assert property (  // RQ10
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && !on_measure |=> !running_q)
        else $error("interval printing ran off the measure screen");

    a_stats_print_level: assert property (  // RQ11
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && stats_print |=> job_valid_q && job_q.kind == print_pkg::JOB_STATS
        && job_q.stats_level == level_of($past(stats_valid_count)))
        else $error("statistics printout wrong");

    a_trigger_adds_value: assert property (  // RQ14
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && stats_measure_trigger_input && !stats_print |=> stats_add_q && job_valid_q
        && job_q.kind == print_pkg::JOB_MEASURE)
        else $error("trigger did not add and print value");

    a_edge_once: assert property (  // RQ17
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && req_edge |=> !req_edge)
        else $error("held request produced two edges");

endmodule : interval_print_controller

/* File: dv/printer_model.sv */
`timescale 1ns/100ps

module printer_model #(
    parameter int BIT_CYCLES = 4
) (
    // Clock and serial line
    input  wire logic       ref_clk,
    input  wire logic       txd,
    // Received character
    output logic [7:0]      rx_byte,
    output logic            rx_done,
    output logic            frame_err
);
    int i;

    initial begin
        rx_byte = 8'h00;
        rx_done = 1'b0;
        frame_err = 1'b0;
        forever begin
            @(negedge txd);
            repeat (BIT_CYCLES / 2) @(posedge ref_clk);
            for (i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge ref_clk);
                rx_byte[i] = txd;
            end
            repeat (BIT_CYCLES) @(posedge ref_clk);
            frame_err = (txd !== 1'b1);
            // plain text is printed as it arrives
            rx_done = 1'b1;
            @(posedge ref_clk);
            rx_done = 1'b0;
        end
    end
endmodule : printer_model

/* File: dv/testbench.sv */
`timescale 1ns/100ps
`include "print_map.svh"

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module testbench;
    logic                  ref_clk;
    logic                  rst_n;
    logic                  clk_en;
    logic                  print_key;
    logic                  trigger_key;
    print_pkg::screen_e    screen;
    logic                  print_req_n;
    logic                  measure_trigger_n;
    logic                  stats_enable;
    logic                  internal_trigger_sel;
    logic [15:0]           stats_valid_count;
    logic [3:0]            reg_addr;
    logic [31:0]           reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [31:0]           reg_rdata_q;
    logic [31:0]           rd;
    logic                  job_valid_q;
    print_pkg::print_job_s job_q;
    logic                  stats_add_q;
    logic                  running_q;
    logic                  txd_q;
    logic [7:0]            rx_byte;
    logic                  rx_done;
    logic                  frame_err;
    logic [14:0]           exp_cnt;
    int                    err_total;
    int                    checked;
    int                    n;

    interval_print_controller #(.SEC_CYCLES(20), .BIT_CYCLES(4)) interval_print_controller_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .print_key(print_key),
        .trigger_key(trigger_key), .screen(screen), .print_req_n(print_req_n),
        .measure_trigger_n(measure_trigger_n), .stats_enable(stats_enable),
        .internal_trigger_sel(internal_trigger_sel), .stats_valid_count(stats_valid_count),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .job_valid_q(job_valid_q), .job_q(job_q),
        .stats_add_q(stats_add_q), .running_q(running_q), .txd_q(txd_q));

    printer_model #(.BIT_CYCLES(4)) printer_model_i (
        .ref_clk(ref_clk), .txd(txd_q), .rx_byte(rx_byte), .rx_done(rx_done),
        .frame_err(frame_err));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata_q;
    endtask : reg_read

    // One-cycle key pulse; returns in the cycle where the answer stands
    task automatic press(input logic measure_trigger_input);
        @(posedge ref_clk);
        if (measure_trigger_input) trigger_key <= 1'b1;
        else print_key <= 1'b1;
        @(posedge ref_clk);
        trigger_key <= 1'b0;
        print_key <= 1'b0;
        #1;
    endtask : press

    // Pin held low like an open collector; pull-up returns it high
    task automatic pin(input logic measure_trigger_input);
        n = 0;
        @(posedge ref_clk);
        if (measure_trigger_input) measure_trigger_n <= 1'b0;
        else print_req_n <= 1'b0;
        repeat (16) begin
            @(posedge ref_clk);
            #1;
            n += int'(job_valid_q === 1'b1);
        end
        print_req_n <= 1'b1;
        measure_trigger_n <= 1'b1;
        `CHK("pin jobs", 1, n)
        exp_cnt++;
        repeat (4) @(posedge ref_clk);
    endtask : pin

    task automatic t_reset();
        reg_read(`REG_STATUS);
        `CHK("status reset", 32'h0001_0000, rd)
        reg_read(`REG_CTRL);
        `CHK("ctrl reset", 32'h0000_0000, rd)
        reg_read(4'h2);
        `CHK("unmapped", 32'h0000_0000, rd)
    endtask : t_reset

    task automatic t_measure();
        repeat (2) begin
            press(1'b0);
            `CHK("meas valid", 1'b1, job_valid_q)
            `CHK("meas kind", print_pkg::JOB_MEASURE, job_q.kind)
            `CHK("meas count", exp_cnt, job_q.record_count)
            `CHK("meas running", 1'b0, running_q)
            exp_cnt++;
        end
        screen <= print_pkg::SCREEN_OTHER;
        press(1'b0);
        `CHK("other screen", 1'b0, job_valid_q)
        screen <= print_pkg::SCREEN_MEASURE;
        clk_en <= 1'b0;
        press(1'b0);
        `CHK("frozen", 1'b0, job_valid_q)
        clk_en <= 1'b1;
        pin(1'b0);
    endtask : t_measure

    task automatic t_trigger();
        stats_enable <= 1'b1;
        internal_trigger_sel <= 1'b1;
        press(1'b1);
        `CHK("stats add", 1'b1, stats_add_q)
        `CHK("measure_trigger_input kind", print_pkg::JOB_MEASURE, job_q.kind)
        `CHK("measure_trigger_input count", exp_cnt, job_q.record_count)
        exp_cnt++;
        pin(1'b1);
    endtask : t_trigger

    task automatic t_stats();
        logic [15:0] cnts [3];
        cnts = '{16'h0000, 16'h0001, 16'h0005};
        screen <= print_pkg::SCREEN_STATS;
        for (int k = 0; k < 3; k++) begin
            stats_valid_count <= cnts[k];
            press(1'b0);
            `CHK("stats kind", print_pkg::JOB_STATS, job_q.kind)
            `CHK("stats level", 2'(k), job_q.stats_level)
        end
        screen <= print_pkg::SCREEN_MEASURE;
        stats_enable <= 1'b0;
    endtask : t_stats

    task automatic t_interval();
        reg_write(`REG_CTRL, 32'h0000_0002);
        press(1'b0);
        `CHK("int run", 1'b1, running_q)
        `CHK("int kind", print_pkg::JOB_INTERVAL, job_q.kind)
        `CHK("int start", 19'h00000, job_q.elapsed)
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (job_valid_q !== 1'b1 && n < 100);
        `CHK("int period", 40, n)
        `CHK("int elapsed", 19'h00002, job_q.elapsed)
        reg_read(`REG_ELAPSED);
        `CHK("elapsed reg", 32'h0000_0002, rd)
        press(1'b0);
        `CHK("int stop", 1'b0, running_q)
        press(1'b0);
        `CHK("int restart", 1'b1, running_q)
        screen <= print_pkg::SCREEN_OTHER;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK("leave screen", 1'b0, running_q)
        screen <= print_pkg::SCREEN_MEASURE;
        reg_write(`REG_CTRL, 32'h0000_0FFF);
        reg_read(`REG_CTRL);
        `CHK("int max", 32'h0000_0E10, rd)
        reg_write(`REG_CTRL, 32'h0000_0000);
    endtask : t_interval

    task automatic t_serial();
        logic [7:0] bytes [2];
        bytes = '{8'h5A, 8'hA5};
        for (int k = 0; k < 2; k++) begin
            reg_write(`REG_TXDATA, {24'h000000, bytes[k]});
            reg_read(`REG_STATUS);
            `CHK("tx busy", 1'b1, rd[1])
            n = 0;
            do begin
                @(posedge ref_clk);
                #1;
                n++;
            end while (rx_done !== 1'b1 && n < 100);
            `CHK("rx byte", bytes[k], rx_byte)
            `CHK("rx stop", 1'b0, frame_err)
            repeat (8) @(posedge ref_clk);
        end
    endtask : t_serial

    task automatic t_wrap();
        while (exp_cnt != 15'h7530) begin
            press(1'b0);
            exp_cnt++;
        end
        press(1'b0);
        `CHK("count last", 15'h7530, job_q.record_count)
        press(1'b0);
        `CHK("count wrap", 15'h0001, job_q.record_count)
    endtask : t_wrap

    task automatic results();
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    initial begin
        #900000;
        err_total++;
        results();
    end

    initial begin
        err_total = 0;
        checked = 0;
        exp_cnt = 15'h0001;
        rst_n = 1'b0;
        clk_en = 1'b1;
        print_key = 1'b0;
        trigger_key = 1'b0;
        screen = print_pkg::SCREEN_MEASURE;
        print_req_n = 1'b1;
        measure_trigger_n = 1'b1;
        stats_enable = 1'b0;
        internal_trigger_sel = 1'b0;
        stats_valid_count = 16'h0000;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_measure();
        t_trigger();
        t_stats();
        t_interval();
        t_serial();
        t_wrap();
        results();
    end
endmodule : testbench
